// ==== rtl/smd_pkg.sv ====
package smd_pkg;

    // apb register map, byte addresses
    localparam int SMD_AW = 8;
    localparam logic [7:0] SMD_OFS_CTRL = 8'h00;
    localparam logic [7:0] SMD_OFS_BYTE = 8'h04;
    localparam logic [7:0] SMD_OFS_NVCFG = 8'h08;
    localparam logic [7:0] SMD_OFS_REGSEL = 8'h0c;
    localparam logic [7:0] SMD_OFS_REGDATA = 8'h10;
    localparam logic [7:0] SMD_OFS_TBL_FIRST = 8'h48;
    localparam logic [7:0] SMD_OFS_TBL_LAST = 8'h63;
    localparam logic [7:0] SMD_LEGACY_SHIFT = 8'h02;
    localparam int SMD_WORDS = 7;

    // emulated configuration register addresses and bit positions
    localparam logic [31:0] SMD_NVREG_THREE_ADDR = 32'h0000_0004;
    localparam logic [31:0] SMD_NVREG_ONE_ADDR = 32'h0000_0002;
    localparam int SMD_BIT_ARCH = 3;
    localparam int SMD_BIT_UNIFORM = 1;
    localparam int SMD_BIT_PARAM_TOP = 2;
    localparam logic [7:0] SMD_MASK_ARCH = 8'h08;
    localparam logic [7:0] SMD_MASK_PARAM_TOP = 8'h04;
    localparam logic [7:0] SMD_MASK_UNIFORM = 8'h02;

    // descriptor field values
    localparam logic [7:0] SMD_INSTR_READ_ANY = 8'h65;
    localparam logic [1:0] SMD_ADDR_LEN_VAR = 2'h3;
    localparam logic [3:0] SMD_LATENCY_VAR = 4'hf;
    localparam logic [1:0] SMD_RFU2 = 2'h3;
    localparam logic [5:0] SMD_RFU6 = 6'h3f;
    localparam logic [7:0] SMD_RFU8 = 8'hff;
    localparam logic [7:0] SMD_REGION_CNT_M1 = 8'h02;
    localparam logic [7:0] SMD_CONFIG_ID = 8'h01;

    // ctrl and byte register fields
    localparam int SMD_CTRL_LEGACY_BIT = 8;
    localparam int SMD_BYTE_VALID_BIT = 8;

    typedef struct packed {
        logic [7:0] mask;
        logic [1:0] addr_len;
        logic [1:0] rfu_a;
        logic [3:0] latency;
        logic [7:0] instr;
        logic [5:0] rfu_b;
        logic map_desc;
        logic end_flag;
    } smd_cmd_desc_t;

    typedef struct packed {
        logic [7:0] rfu;
        logic [7:0] region_cnt;
        logic [7:0] config_id;
        logic [5:0] rfu_b;
        logic map_desc;
        logic end_flag;
    } smd_map_hdr_t;

    typedef struct packed {
        logic uniform_block_size_select;
        logic param_sector_top_select;
        logic architecture_select;
    } smd_nvcfg_t;

    typedef struct packed {
        logic pslverr;
        logic [31:0] prdata;
    } smd_apb_rsp_t;

    function automatic logic [31:0] smd_cmd(input logic [7:0] mask, input logic last);
        smd_cmd_desc_t d;
        d = '{mask, SMD_ADDR_LEN_VAR, SMD_RFU2, SMD_LATENCY_VAR,
              SMD_INSTR_READ_ANY, SMD_RFU6, 1'b0, last};
        return d;
    endfunction

    localparam smd_map_hdr_t SMD_HDR = '{SMD_RFU8, SMD_REGION_CNT_M1, SMD_CONFIG_ID, SMD_RFU6, 1'b1, 1'b0};

    // table words, lowest byte at lowest offset
    localparam logic [31:0] SMD_TABLE [SMD_WORDS] = '{
        smd_cmd(SMD_MASK_ARCH, 1'b0),
        SMD_NVREG_THREE_ADDR,
        smd_cmd(SMD_MASK_PARAM_TOP, 1'b0),
        SMD_NVREG_ONE_ADDR,
        smd_cmd(SMD_MASK_UNIFORM, 1'b1),
        SMD_NVREG_THREE_ADDR,
        SMD_HDR
    };

endpackage

// ==== rtl/smd_table.sv ====
// Contract
// - first detect descriptor names register address 4 holding architecture bit.
// - second detect descriptor carries mask 0000_0100b, keeping bit 2.
// - placement bit reads 0 for bottom parameter sectors, 1 for top.
// - second detect descriptor names register address 2.
// - third detect descriptor carries mask 0000_0010b and register address 4.
// - uniform size bit reads 0 for 64-KB, 1 for 256-KB sectors.
// - every detect descriptor encodes 65h, address length 11b, latency 1111b.
// - only the third detect descriptor sets bit 0, the end flag.
// - bit 1 of each detect descriptor first dword is 0.
// - first header region count field 02h in bits 23:16.
// - first header configuration identifier 01h in bits 15:8.
// - header bit 1 set (map descriptor), bit 0 clear.
// - reserved fields read as all ones, header 31:24 is FFh.
// - architecture bit 3 at address 4 reads 0 hybrid, 1 uniform.
`timescale 1ns/1ps
module smd_table #(
    parameter logic ARCH_RESET = 1'b0,
    parameter logic PARAM_TOP_RESET = 1'b0,
    parameter logic UNIFORM_RESET = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smd_pkg::SMD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration bits as held
    output smd_pkg::smd_nvcfg_t nv_cfg
);
    import smd_pkg::*;

    logic [15:0] ctrl;
    logic [7:0] reg_sel;
    logic access;
    logic commit;
    logic [7:0] view_ofs;
    logic view_hit;
    logic [7:0] rel_ofs;
    logic [2:0] word_idx;
    logic [31:0] word_val;
    logic [7:0] table_byte;
    logic [7:0] reg_byte;
    smd_apb_rsp_t next_rsp;

    // transfer taken in the second access cycle, pready high for one cycle
    assign access = psel && penable && !pready;
    assign commit = psel && penable && pready && pwrite;

    // legacy view sits two bytes above the native view
    always_comb begin
        view_ofs = ctrl[7:0];
        if (ctrl[SMD_CTRL_LEGACY_BIT]) begin
            view_ofs = ctrl[7:0] - SMD_LEGACY_SHIFT;
        end
    end

    assign view_hit = (view_ofs >= SMD_OFS_TBL_FIRST) && (view_ofs <= SMD_OFS_TBL_LAST);
    assign rel_ofs = view_ofs - SMD_OFS_TBL_FIRST;
    assign word_idx = view_hit ? rel_ofs[4:2] : 3'h0;
    // table words are fixed, so the byte view and the word view can never disagree
    assign word_val = SMD_TABLE[word_idx];
    // header fields come from the same table word six
    logic hdr_sel;
    assign hdr_sel = (word_idx == 3'h6);

    // byte lane picked low byte first
    always_comb begin
        unique case (rel_ofs[1:0])
            2'h0: table_byte = word_val[7:0];
            2'h1: table_byte = word_val[15:8];
            2'h2: table_byte = word_val[23:16];
            2'h3: table_byte = word_val[31:24];
        endcase
    end

    // emulated read of the nonvolatile configuration registers
    always_comb begin
        reg_byte = 8'h00;
        if ({24'h000000, reg_sel} == SMD_NVREG_THREE_ADDR) begin
            reg_byte[SMD_BIT_ARCH] = nv_cfg.architecture_select;
            reg_byte[SMD_BIT_UNIFORM] = nv_cfg.uniform_block_size_select;
        end else if ({24'h000000, reg_sel} == SMD_NVREG_ONE_ADDR) begin
            reg_byte[SMD_BIT_PARAM_TOP] = nv_cfg.param_sector_top_select;
        end
    end

    // read data and error decode; unmapped addresses answer with pslverr
    always_comb begin
        next_rsp = '0;
        if (paddr >= SMD_OFS_TBL_FIRST && paddr <= SMD_OFS_TBL_LAST && paddr[1:0] == 2'h0) begin
            next_rsp.prdata = SMD_TABLE[3'((paddr - SMD_OFS_TBL_FIRST) >> 2)];
            next_rsp.pslverr = pwrite; // table is read-only
        end else begin
            unique case (paddr)
                SMD_OFS_CTRL: next_rsp.prdata = {16'h0000, ctrl};
                SMD_OFS_BYTE: begin
                    next_rsp.prdata[7:0] = view_hit ? table_byte : 8'h00;
                    next_rsp.prdata[SMD_BYTE_VALID_BIT] = view_hit;
                    next_rsp.pslverr = pwrite;
                end
                SMD_OFS_NVCFG: next_rsp.prdata = {29'h00000000, nv_cfg};
                SMD_OFS_REGSEL: next_rsp.prdata = {24'h000000, reg_sel};
                SMD_OFS_REGDATA: begin
                    next_rsp.prdata = {24'h000000, reg_byte};
                    next_rsp.pslverr = pwrite;
                end
                default: next_rsp.pslverr = 1'b1;
            endcase
        end
    end

    // apb handshake, one wait state per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // response captured with pready so it stands while the master samples it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rsp.prdata;
            pslverr <= next_rsp.pslverr;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // byte offset and view select, honouring strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 16'h0000;
        end else if (commit && paddr == SMD_OFS_CTRL) begin
            if (pstrb[0]) begin
                ctrl[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl[15:8] <= {7'h00, pwdata[SMD_CTRL_LEGACY_BIT]};
            end
        end
    end

    // configuration bits steer what the register read returns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_cfg <= '{UNIFORM_RESET, PARAM_TOP_RESET, ARCH_RESET};
        end else if (commit && paddr == SMD_OFS_NVCFG && pstrb[0]) begin
            nv_cfg <= pwdata[2:0];
        end
    end

    // register select for the emulated read any register path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_sel <= 8'h00;
        end else if (commit && paddr == SMD_OFS_REGSEL && pstrb[0]) begin
            reg_sel <= pwdata[7:0];
        end
    end

endmodule // smd_table

// ==== sim/smd_table_asserts.sv ====
`timescale 1ns/1ps
module smd_table_asserts (
    // clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smd_pkg::SMD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // config
    input wire smd_pkg::smd_nvcfg_t nv_cfg
);
    import smd_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a read answer, settled in the pready cycle
    wire rd = pready && !pwrite;
    // answer timing: one wait, one-cycle pulse
    chk_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer after one wait");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    chk_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("outputs not idle");
    // fixed words, literals kept apart from the package on purpose
    chk_first_desc: assert property (rd && paddr == 8'h48 |-> prdata == 32'h08ff65fc)
        else $error("first descriptor wrong");
    chk_last_desc: assert property (rd && paddr == 8'h58 |-> prdata == 32'h02ff65fd)
        else $error("end descriptor wrong");
    chk_hdr_word: assert property (rd && paddr == 8'h60 |-> prdata == 32'hff0201fe)
        else $error("map header wrong");
    chk_tbl_ro: assert property (pready && pwrite && paddr inside {[8'h48:8'h63]} |-> pslverr)
        else $error("table write accepted");
    // config changes only by an accepted write
    chk_cfg_hold: assert property (!(pready && pwrite && paddr == 8'h08) |=> $stable(nv_cfg))
        else $error("config moved");
    chk_cfg_write: assert property (pready && pwrite && pstrb[0] && paddr == 8'h08 |=> nv_cfg == $past(pwdata[2:0]))
        else $error("config not written");
    cover property (pready && pslverr);
    cover property (pready && pwrite && paddr == 8'h08);
    cover property (rd && paddr == 8'h60);
endmodule // smd_table_asserts

bind smd_table smd_table_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_cfg(nv_cfg));

// ==== sim/smd_host_model.sv ====
`timescale 1ns/1ps
module smd_host_model (
    // register bytes returned by the three detection reads
    input wire logic [7:0] reg_three_byte,
    input wire logic [7:0] reg_one_byte,
    // selected map
    output logic [2:0] map_index
);
    // masked bits, msb first; walked until the end flag of the third descriptor
    assign map_index = {|(reg_three_byte & 8'h08), |(reg_one_byte & 8'h04), |(reg_three_byte & 8'h02)};
endmodule // smd_host_model

// ==== sim/smd_table_tb_top.sv ====
`timescale 1ns/1ps
module smd_table_tb_top;
    import smd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    smd_nvcfg_t nv_cfg;
    logic [7:0] b4 = 8'h00;
    logic [7:0] b2 = 8'h00;
    logic [2:0] idx;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int total_checks = 0;
    always #2.5 pclk = ~pclk;
    smd_table u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nv_cfg(nv_cfg));
    smd_host_model u_host (.reg_three_byte(b4), .reg_one_byte(b2), .map_index(idx));
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reset values, then refused places
    task automatic s_err;
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 8'h49, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h48, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h04, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h0c, 32'h4);
        apb(1'b0, 8'h0c, 32'h0);
        chk({err, rd[30:0]}, 32'h4);
        apb(1'b0, 8'h48, 32'h0);
        chk(rd, 32'h08ff65fc);
    endtask
    // all table words in turn
    task automatic s_table;
        logic [31:0] exp [7] = '{32'h08ff65fc, 32'h4, 32'h04ff65fc, 32'h2, 32'h02ff65fd, 32'h4, 32'hff0201fe};
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, 8'h48 + 8'(4 * k), 32'h0);
            chk(rd, exp[k]);
        end
    endtask
    // single bytes, native and legacy offsets
    task automatic s_bytes;
        apb(1'b1, 8'h00, 32'h04b);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h108);
        apb(1'b1, 8'h00, 32'h14d);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h108);
        apb(1'b1, 8'h00, 32'h165);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1ff);
    endtask
    // every config combination read back as the host would
    task automatic s_cfg;
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, 8'h08, 32'(v));
            apb(1'b1, 8'h0c, 32'h4);
            apb(1'b0, 8'h10, 32'h0);
            b4 <= rd[7:0];
            apb(1'b1, 8'h0c, 32'h2);
            apb(1'b0, 8'h10, 32'h0);
            b2 <= rd[7:0];
            @(posedge pclk);
            chk({29'h0, idx}, {29'h0, v[0], v[1], v[2]});
            chk({29'h0, nv_cfg}, 32'(v));
        end
        // a write with no lane strobe must leave the configuration alone
        pstrb <= 4'h0;
        apb(1'b1, 8'h08, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h7);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_err();
        s_table();
        s_bytes();
        s_cfg();
        end_sim();
    end
endmodule // smd_table_tb_top
